/* File: rtl/pic_counter.sv */
// Purpose: One 16-bit down-counter channel with modes 0 to 5, gate and output pin.
// Assumes: Host writes arrive on i_clk as one-cycle strobes; count clock and gate are pins.
// Notes: Count clock edges are found by oversampling on i_clk, so it must run well below 25 MHz.
// Overview of operation
// - Mode 2: output high, low for one pulse at count one, reload, period N.
// - Mode 2: gate falling forces output high; trigger reloads on next pulse.
// - Mode 2: after control word and count, load on next pulse, low N later.
// - Mode 2: new count waits for period end unless a trigger reloads it.
// - Mode 3: output high first half of count, low second half, period N.
// - Mode 3: gate falling forces output high at once; trigger reloads next pulse.
// - Mode 3: new count loads on trigger, otherwise at end of half-cycle.
// - Mode 3 even: load, then subtract two; at expiry toggle and reload.
// - Mode 3 odd: first step one when high, three when low, then two.
// - Mode 4: count write starts, one-pulse low strobe on expiry, gate only enables.
// - Mode 4: load pulse does not decrement, strobe N+1 pulses after write.
// - Mode 4: first of two bytes changes nothing; second byte reloads next pulse.
// - Mode 5: trigger loads next pulse, strobe N+1 pulses later, retriggerable.
// - Mode 5: new count waits unless a trigger comes before expiry.
// - Control word write resets control logic and output at once.
// - Gate level sampled each rising pulse edge; enables counting in 0,2,3,4.
// - Gate rising edge sets a capture flop, sampled and cleared at next rise.
// - Loads and decrements happen on the falling count clock edge.
// - Initial count zero means 65536 binary or 10000 decimal.
// - Modes 0,1,4,5 wrap to FFFF or 9999; modes 2,3 reload.
// - Mode 1: trigger starts counting and drives output low after next pulse.
// - Control word holds byte select, three-bit mode and decimal select.
`include "pic_regs.svh"

module pic_counter (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_cnt_clk,
   input wire logic i_gate,
   input wire pic_pkg::pic_wr_t i_wr,
   output logic o_out,
   output logic [`PIC_CNT_W-1:0] o_count
);
   import pic_pkg::*;

   localparam int CW = `PIC_CNT_W;

   // Binary or decimal-coded decrement by one; zero wraps to the top count.
   function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v, input logic bcd);
      logic [CW-1:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (bcd) begin
         for (int i = 0; i < CW / 4; i++) begin
            if (borrow) begin
               if (r[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9;
               end else begin
                  r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end else begin
         r = v - {{(CW-1){1'b0}}, 1'b1};
      end
      return r;
   endfunction

   function automatic logic [CW-1:0] dec_by(input logic [CW-1:0] v, input logic [1:0] step,
                                           input logic bcd);
      logic [CW-1:0] r;
      r = v;
      for (int k = 0; k < 3; k++) begin
         if (k < int'(step)) begin
            r = dec1(r, bcd);
         end
      end
      return r;
   endfunction

   // Modes six and seven behave as two and three.
   function automatic pic_mode_t mode_of(input logic [2:0] m);
      pic_mode_t r;
      if (m[1]) begin
         r = pic_mode_t'({1'b0, m[1:0]});
      end else begin
         r = pic_mode_t'(m);
      end
      return r;
   endfunction

   // Pin synchronisers: bit 0 count clock, bit 1 gate.
   // The count clock and the gate are asynchronous to i_clk, so two stages settle them.
   // The third stage only gives the previous settled level for edge detection.
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] sync3_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         sync3_r <= 2'h0;
      end else begin
         sync1_r <= {i_gate, i_cnt_clk};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   wire clk_rise = sync2_r[0] & ~sync3_r[0];
   wire clk_fall = ~sync2_r[0] & sync3_r[0];
   wire gate_lvl = sync2_r[1];
   wire gate_edge = sync2_r[1] & ~sync3_r[1];

   logic [`PIC_CW_W-1:0] cw_r, cw_nxt;
   logic [CW-1:0] cr_r, cr_nxt;
   logic [CW-1:0] ce_r, ce_nxt;
   logic out_r, out_nxt;
   logic byte_hi_r, byte_hi_nxt;
   logic hold_r, hold_nxt;
   pic_st_t st_r, st_nxt;
   logic wpend_r, wpend_nxt;
   logic load_r, load_nxt;
   logic trig_r, trig_nxt;
   logic gate_s_r, gate_s_nxt;
   logic first_r, first_nxt;
   // Parity of the count that the counting element was last loaded with.
   logic odd_r, odd_nxt;

   // Control word fields.
   wire [1:0] rw = cw_r[`PIC_CW_RW_HI:`PIC_CW_RW_LO];
   wire bcd = cw_r[`PIC_CW_BCD_BIT];
   wire pic_mode_t mode = mode_of(cw_r[`PIC_CW_MODE_HI:`PIC_CW_MODE_LO]);
   wire pic_mode_t mode_w = mode_of(i_wr.data[`PIC_CW_MODE_HI:`PIC_CW_MODE_LO]);

   wire periodic = (mode == PIC_MODE2) || (mode == PIC_MODE3);
   wire edge_mode = periodic || (mode == PIC_MODE1) || (mode == PIC_MODE5);
   wire level_mode = periodic || (mode == PIC_MODE0) || (mode == PIC_MODE4);

   // A latch command (byte select zero) is not a mode write and leaves the channel alone.
   wire cw_wr = i_wr.stb & i_wr.ctrl & (i_wr.data[`PIC_CW_RW_HI:`PIC_CW_RW_LO] != `PIC_RW_LATCH);
   wire cnt_wr = i_wr.stb & ~i_wr.ctrl & (rw != `PIC_RW_LATCH);
   wire first_byte = cnt_wr & (rw == `PIC_RW_BOTH) & ~byte_hi_r;
   wire cnt_done = cnt_wr & ~first_byte;

   wire [CW-1:0] cr_wr = (rw == `PIC_RW_LSB) ? {8'h00, i_wr.data} :
                         (rw == `PIC_RW_MSB) ? {i_wr.data, 8'h00} :
                         first_byte ? {cr_r[15:8], i_wr.data} : {i_wr.data, cr_r[7:0]};

   // Level-sensitive modes count only while the gate sampled at the last rise was high.
   // A first byte in mode 0 holds the count until the second byte arrives.
   wire count_en = (level_mode ? gate_s_r : 1'b1) & ~hold_r;
   // A trigger is only taken once a complete count has been written.
   wire trig_take = trig_r & edge_mode & (st_r != PIC_ST_IDLE);
   wire [CW-1:0] ce_dec1 = dec1(ce_r, bcd);
   // The first step after a load follows the parity of the loaded count, not of the
   // holding register, which the host may already have rewritten for the next reload.
   wire [1:0] step3 = (first_r & odd_r) ? (out_r ? 2'h1 : 2'h3) : 2'h2;
   wire [CW-1:0] ce_dec3 = dec_by(ce_r, step3, bcd);
   wire expire3 = (ce_r == {{(CW-2){1'b0}}, step3});
   wire ce_is_one = (ce_r == {{(CW-1){1'b0}}, 1'b1});
   wire ce_dec_zero = (ce_dec1 == `PIC_CNT_RST);

   always_comb begin
      cw_nxt = cw_r;
      cr_nxt = cr_r;
      ce_nxt = ce_r;
      out_nxt = out_r;
      byte_hi_nxt = byte_hi_r;
      hold_nxt = hold_r;
      st_nxt = st_r;
      wpend_nxt = wpend_r;
      load_nxt = load_r;
      gate_s_nxt = gate_s_r;
      first_nxt = first_r;
      odd_nxt = odd_r;
      // The capture flop is set by a gate edge even in the cycle it is sampled.
      trig_nxt = gate_edge | (trig_r & ~clk_rise);
      if (cw_wr) begin
         cw_nxt = i_wr.data[`PIC_CW_W-1:0];
         out_nxt = (mode_w != PIC_MODE0);
         st_nxt = PIC_ST_IDLE;
         byte_hi_nxt = 1'b0;
         hold_nxt = 1'b0;
         wpend_nxt = 1'b0;
         load_nxt = 1'b0;
         first_nxt = 1'b0;
         odd_nxt = 1'b0;
         trig_nxt = gate_edge;
      end else begin
         // A full pulse (rise then fall) must pass before a load takes effect.
         if (clk_rise) begin
            gate_s_nxt = gate_lvl;
            load_nxt = wpend_r | trig_take;
            wpend_nxt = 1'b0;
         end
         if (clk_fall && load_r) begin
            ce_nxt = cr_r;
            st_nxt = PIC_ST_RUN;
            load_nxt = 1'b0;
            first_nxt = 1'b1;
            odd_nxt = cr_r[0];
            out_nxt = (mode != PIC_MODE1) && (mode != PIC_MODE0);
         end else if (clk_fall && (st_r == PIC_ST_RUN) && count_en) begin
            first_nxt = 1'b0;
            case (mode)
               // Modes 0 and 1 raise the output when the count reaches zero and keep
               // wrapping; the output then stays high until a mode 0 control word or count write, or in mode 1 a trigger.
               PIC_MODE0, PIC_MODE1: begin
                  ce_nxt = ce_dec1;
                  if (ce_dec_zero) begin
                     out_nxt = 1'b1;
                  end
               end
               // Modes 4 and 5 strobe low for the single pulse in which the count is zero.
               // The gate never reaches the output here; it only enables counting in mode 4 and triggers a reload in mode 5.
               PIC_MODE4, PIC_MODE5: begin
                  ce_nxt = ce_dec1;
                  out_nxt = ~ce_dec_zero;
               end
               // Mode 2 reloads on the pulse that would take the count from one to zero,
               // so the low pulse spans exactly one count clock and the period stays N.
               PIC_MODE2: begin
                  if (ce_is_one) begin
                     ce_nxt = cr_r;
                     out_nxt = 1'b1;
                  end else begin
                     ce_nxt = ce_dec1;
                     out_nxt = (ce_dec1 != {{(CW-1){1'b0}}, 1'b1});
                  end
               end
               // Mode 3 steps by two; an odd count spends its extra pulse in the high half.
               // Each half ends with a reload, which is where a rewritten count takes over.
               PIC_MODE3: begin
                  if (expire3) begin
                     ce_nxt = cr_r;
                     out_nxt = ~out_r;
                     first_nxt = 1'b1;
                     odd_nxt = cr_r[0];
                  end else begin
                     ce_nxt = ce_dec3;
                  end
               end
               default: begin
                  ce_nxt = ce_r;
               end
            endcase
         end
         if (cnt_wr) begin
            cr_nxt = cr_wr;
            byte_hi_nxt = first_byte;
            if (mode == PIC_MODE0) begin
               out_nxt = 1'b0;
               hold_nxt = first_byte;
            end
            if (cnt_done) begin
               // Once running, periodic modes pick a new count up at reload or on a trigger only.
               if (!periodic || (st_r != PIC_ST_RUN)) begin
                  wpend_nxt = (mode != PIC_MODE1) && (mode != PIC_MODE5);
               end
               if (st_r == PIC_ST_IDLE) begin
                  st_nxt = PIC_ST_ARMED;
               end
            end
         end
         // In the periodic modes a low gate lifts the output at once, whatever else
         // this cycle decided; counting itself stops at the next sampled rise.
         if (periodic && !gate_lvl) begin
            out_nxt = 1'b1;
         end
      end
   end

   // Configuration: control word and count holding register.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cw_r <= `PIC_CW_RST;
         cr_r <= `PIC_CNT_RST;
      end else begin
         cw_r <= cw_nxt;
         cr_r <= cr_nxt;
      end
   end

   // Counting element and the step selection that follows each load.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ce_r <= `PIC_CNT_RST;
         first_r <= 1'b0;
         odd_r <= 1'b0;
      end else begin
         ce_r <= ce_nxt;
         first_r <= first_nxt;
         odd_r <= odd_nxt;
      end
   end

   // Output pin register.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   // Sequencing: byte pairing, hold, state, pending load and gate capture.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         byte_hi_r <= 1'b0;
         hold_r <= 1'b0;
         st_r <= PIC_ST_IDLE;
         wpend_r <= 1'b0;
         load_r <= 1'b0;
         trig_r <= 1'b0;
         gate_s_r <= 1'b0;
      end else begin
         byte_hi_r <= byte_hi_nxt;
         hold_r <= hold_nxt;
         st_r <= st_nxt;
         wpend_r <= wpend_nxt;
         load_r <= load_nxt;
         trig_r <= trig_nxt;
         gate_s_r <= gate_s_nxt;
      end
   end

   assign o_out = out_r;
   assign o_count = ce_r;

endmodule

/* File: rtl/pic_pkg.sv */
// Purpose: Types shared by the interval counter channel.
// Assumes: Nothing beyond the constants header.
// Notes: Modes six and seven alias modes two and three.
package pic_pkg;

   typedef enum logic [2:0] {
      PIC_MODE0 = 3'h0,
      PIC_MODE1 = 3'h1,
      PIC_MODE2 = 3'h2,
      PIC_MODE3 = 3'h3,
      PIC_MODE4 = 3'h4,
      PIC_MODE5 = 3'h5
   } pic_mode_t;

   typedef enum logic [2:0] {
      PIC_ST_IDLE = 3'b001,
      PIC_ST_ARMED = 3'b010,
      PIC_ST_RUN = 3'b100
   } pic_st_t;

   typedef struct packed {
      logic stb;
      logic ctrl;
      logic [7:0] data;
   } pic_wr_t;

endpackage

/* File: rtl/pic_regs.svh */
// Purpose: Constants for one programmable interval counter channel.
// Assumes: Control word bits 5..0 carry byte select, mode and decimal select.
// Notes: Definitions only.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

`define PIC_CNT_W 16
`define PIC_CW_BCD_BIT 0
`define PIC_CW_MODE_LO 1
`define PIC_CW_MODE_HI 3
`define PIC_CW_RW_LO 4
`define PIC_CW_RW_HI 5
`define PIC_CW_W 6
`define PIC_CW_RST 6'h00
`define PIC_RW_LSB 2'h1
`define PIC_RW_MSB 2'h2
`define PIC_RW_BOTH 2'h3
`define PIC_RW_LATCH 2'h0
`define PIC_CNT_RST 16'h0000

`endif

/* File: verification/pic_counter_sva.sv */
// Purpose: Port-level checks of one interval counter channel.
// Assumes: Count clock is much slower than i_clk; counts are written LSB only.
// Notes: Mode and count are tracked from host writes.
module pic_counter_sva (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_cnt_clk,
   input wire logic i_gate,
   input wire pic_pkg::pic_wr_t i_wr,
   input wire logic o_out,
   input wire logic [15:0] o_count
);
   import pic_pkg::*;
   logic [2:0] mode_r;
   logic [7:0] hold_r;
   logic clk_q_r;
   logic [3:0] age_r;
   wire cw_take = i_wr.stb && i_wr.ctrl && (i_wr.data[5:4] != 2'h0);
   wire m2 = (mode_r[1:0] == 2'h2);
   wire m3 = (mode_r[1:0] == 2'h3);
   wire m45 = (mode_r == 3'h4) || (mode_r == 3'h5);
   wire fell_seen = (age_r >= 4'h1) && (age_r <= 4'h6);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_r <= 3'h0;
         hold_r <= 8'h00;
         clk_q_r <= 1'b0;
         age_r <= 4'hF;
      end else begin
         clk_q_r <= i_cnt_clk;
         age_r <= (clk_q_r && !i_cnt_clk) ? 4'h0 : ((age_r == 4'hF) ? age_r : age_r + 4'h1);
         if (cw_take) mode_r <= i_wr.data[3:1];
         if (i_wr.stb && !i_wr.ctrl) hold_r <= i_wr.data;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   cw_out_high_a: assert property (cw_take && i_wr.data[3:1] != 3'h0 |=> o_out)
      else $error("output not high after control word");
   cw_out_low_a: assert property (cw_take && i_wr.data[3:1] == 3'h0 |=> !o_out)
      else $error("output not low after mode zero control word");
   load_on_fall_a: assert property ($changed(o_count) && !$past(i_wr.stb) |-> fell_seen)
      else $error("count changed away from a count clock fall");
   rate_low_one_a: assert property (m2 && !o_out |-> o_count == 16'h0001)
      else $error("rate output low while count is not one");
   strobe_zero_a: assert property (m45 && !o_out |-> o_count == 16'h0000)
      else $error("strobe low while count is not zero");
   strobe_width_a: assert property (m45 && $fell(o_out) |-> !o_out [*8] ##[1:4] o_out)
      else $error("strobe is not one count clock long");
   gate_force_a: assert property ((m2 || m3) && !o_out && $fell(i_gate) |-> ##[1:5] o_out)
      else $error("gate low did not force output high");
   gate_no_out_a: assert property (m45 && $changed(o_out) && !$past(i_wr.stb) |-> fell_seen)
      else $error("strobe output moved without a count clock fall");
   sq_step_two_a: assert property (m3 && $changed(o_count) && !$past(o_count[0]) && $past(o_count) > 16'h0002
      |-> o_count == $past(o_count) - 16'h0002 || o_count == {8'h00, hold_r})
      else $error("square wave count did not step by two");
endmodule
bind pic_counter pic_counter_sva pic_counter_sva_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_cnt_clk(i_cnt_clk), .i_gate(i_gate), .i_wr(i_wr), .o_out(o_out), .o_count(o_count));

/* File: verification/pic_host_model.sv */
// Purpose: Host side that writes control words and count bytes.
// Assumes: Writes are one i_clk strobes launched at the falling edge.
// Notes: Callers keep counts of at least 2 in modes 2 and 3.
module pic_host_model (
   input wire logic i_clk,
   output pic_pkg::pic_wr_t o_wr
);
   import pic_pkg::*;
   initial o_wr = '0;
   task automatic wr(input logic ctrl, input logic [7:0] d);
      @(negedge i_clk) o_wr <= {1'b1, ctrl, d};
      @(negedge i_clk) o_wr <= '0;
   endtask
endmodule

/* File: verification/tb_programmable_interval_counter_modes.sv */
// Purpose: Self-checking bench for the interval counter channel.
// Assumes: Count clock period is ten system clocks.
// Notes: Strobe and period timings are measured in system clocks.
module tb_programmable_interval_counter_modes;
   timeunit 1ns;
   timeprecision 1ps;
   import pic_pkg::*;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_cnt_clk = 1'b0, i_gate = 1'b1;
   pic_wr_t i_wr;
   logic o_out;
   logic [15:0] o_count;
   int num_errors = 0, n_checks = 0, cyc = 0, div = 0, t, t1, t2;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
   always #5 i_clk = ~i_clk;
   always @(negedge i_clk) begin
      cyc++;
      div = (div == 4) ? 0 : div + 1;
      if (div == 0) i_cnt_clk = ~i_cnt_clk;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end
   pic_counter pic_counter_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cnt_clk(i_cnt_clk),
      .i_gate(i_gate), .i_wr(i_wr), .o_out(o_out), .o_count(o_count));
   pic_host_model pic_host_model_inst (.i_clk(i_clk), .o_wr(i_wr));
   task automatic wait_out(input logic v, output int n);
      n = 0;
      while (o_out !== v && n < 2000) begin
         @(negedge i_clk);
         n++;
      end
      `CHK(o_out, v)
   endtask
   task automatic prog(input logic [7:0] cw, input logic [7:0] n);
      pic_host_model_inst.wr(1'b1, cw);
      pic_host_model_inst.wr(1'b0, n);
   endtask
   task automatic t_mode2();
      prog(8'h14, 8'h03);
      `CHK(o_out, 1'b1)
      wait_out(0, t);
      wait_out(1, t1);
      wait_out(0, t2);
      `CHK(t1 + t2, 30)
      i_gate = 1'b0;
      wait_out(1, t);
      `CHK(t <= 5, 1'b1)
      t1 = o_count;
      repeat (40) @(negedge i_clk);
      `CHK(o_count, t1[15:0])
      i_gate = 1'b1;
      wait_out(0, t);
      `CHK(t inside {[24:42]}, 1'b1)
      wait_out(1, t);
      pic_host_model_inst.wr(1'b0, 8'h05);
      wait_out(0, t);
      `CHK(t inside {[14:20]}, 1'b1)
      wait_out(1, t1);
      wait_out(0, t2);
      `CHK(t1 + t2, 50)
   endtask
   task automatic t_mode3();
      prog(8'h16, 8'h05);
      wait_out(0, t);
      wait_out(1, t1);
      wait_out(0, t2);
      `CHK(t1, 20)
      `CHK(t2, 30)
      pic_host_model_inst.wr(1'b0, 8'h04);
      wait_out(1, t);
      wait_out(0, t1);
      wait_out(1, t2);
      `CHK(t1, 20)
      `CHK(t2, 20)
      wait_out(0, t);
      i_gate = 1'b0;
      wait_out(1, t);
      `CHK(t <= 5, 1'b1)
      i_gate = 1'b1;
   endtask
   task automatic t_mode4();
      prog(8'h18, 8'h02);
      wait_out(0, t);
      `CHK(t inside {[20:40]}, 1'b1)
      wait_out(1, t);
      `CHK(t, 10)
      `CHK(o_count, 16'hFFFF)
      i_gate = 1'b0;
      t1 = o_count;
      repeat (30) @(negedge i_clk);
      `CHK(o_count, t1[15:0])
      i_gate = 1'b1;
      prog(8'h38, 8'h02);
      repeat (40) @(negedge i_clk);
      `CHK(o_out, 1'b1)
      pic_host_model_inst.wr(1'b0, 8'h00);
      wait_out(0, t);
      `CHK(t inside {[20:40]}, 1'b1)
      wait_out(1, t);
      `CHK(t, 10)
   endtask
   task automatic t_mode5();
      i_gate = 1'b0;
      prog(8'h1A, 8'h02);
      repeat (40) @(negedge i_clk);
      `CHK(o_out, 1'b1)
      i_gate = 1'b1;
      repeat (2) @(negedge i_clk);
      i_gate = 1'b0;
      wait_out(0, t);
      `CHK(t inside {[18:40]}, 1'b1)
      wait_out(1, t);
      `CHK(t, 10)
   endtask
   task automatic t_zero();
      i_gate = 1'b1;
      prog(8'h14, 8'h00);
      repeat (60) @(negedge i_clk);
      `CHK(o_out, 1'b1)
      `CHK(o_count > 16'hFFF0, 1'b1)
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge i_clk);
      i_rst_b = 1'b1;
      @(negedge i_clk);
      t_mode2();
      t_mode3();
      t_mode4();
      t_mode5();
      t_zero();
      final_report();
   end
endmodule
